//--- locr_pkg.sv
// Constants, register map and field layouts for the lead-off current
// and pad configuration register bank.
// Assumes a byte-addressed register bus; each register takes one word.
package locr_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [5:0] IDX_FEATURE_CONFIG_FIVE    = 6'h0E;
	localparam logic [5:0] IDX_LEADOFF_CURRENT_STEP   = 6'h0F;
	localparam logic [5:0] IDX_LEADOFF_THRESHOLD_STEP = 6'h10;
	localparam logic [5:0] IDX_IRQ_STATUS             = 6'h20;
	localparam logic [5:0] IDX_IRQ_MASK               = 6'h21;

	// Values after reset.
	localparam logic [7:0] RST_FEATURE_CONFIG_FIVE    = 8'h71;
	localparam logic [7:0] RST_LEADOFF_CURRENT_STEP   = 8'h00;
	localparam logic [7:0] RST_LEADOFF_THRESHOLD_STEP = 8'h00;
	localparam logic [1:0] RST_IRQ                    = 2'h0;
	localparam logic [2:0] ROUTE_NONE                 = 3'h7;

	// Interrupt status bit positions.
	localparam int IRQ_BIT_FRAME_MISS = 0;
	localparam int IRQ_BIT_DETACH     = 1;
	localparam int IRQ_BITS           = 2;

	// Fine current step in tenths of a nanoampere (2.2 nA).
	localparam logic [4:0] FINE_STEP_TENTHS_NA = 5'h16;
	localparam int         MAG_BITS            = 11;

	// Feature configuration register, bit 7 down to bit 0.
	typedef struct packed {
		logic       osc_check_on;
		logic [2:0] irq_pin_route;
		logic       invalid_cmd_irq_on;
		logic       frame_miss_check_on;
		logic       pad_strong_drive_on;
		logic       pad_slew_limit_on;
	} locr_config_five_t;

	// Lead-off current step register, bit 7 down to bit 0.
	typedef struct packed {
		logic       electrode_detach_irq_on;
		logic       current_source_select;
		logic [5:0] fine_current_code;
	} locr_current_step_t;

	// Excitation current setting handed to the current DAC.
	typedef struct packed {
		logic                fine_selected;
		logic [1:0]          coarse_current_code;
		logic [MAG_BITS-1:0] fine_magnitude;
	} locr_dac_t;

endpackage

//--- locr_frame_check.sv
// Direct output frame overwrite detector.
// Assumes frame strobes come from logic on the same clock.
`timescale 1ns/1ns
module locr_frame_check
	import locr_pkg::*;
(
	// Clock and reset.
	input  wire logic ref_clk,
	input  wire logic reset_n,
	// Control.
	input  wire logic check_on,
	// Frame events.
	input  wire logic frame_new,
	input  wire logic frame_to_fifo,
	input  wire logic frame_taken,
	// Result.
	output logic      frame_miss
);

	logic pending;
	logic direct_new;

	// Frames written into the sample FIFO never count here.
	assign direct_new = frame_new && !frame_to_fifo; // R02

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			pending <= 1'b0;
		else if (direct_new)
			pending <= 1'b1;
		else if (frame_taken)
			pending <= 1'b0;
	end

	// A read in the same cycle as a new frame saves the old one.
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			frame_miss <= 1'b0;
		else
			frame_miss <= check_on && direct_new && pending && !frame_taken; // R01
	end

endmodule

//--- locr_irq_route.sv
// Routes the five interrupt sources onto the two general-purpose pins.
// Purely combinational; the caller registers the outputs.
`timescale 1ns/1ns
module locr_irq_route
	import locr_pkg::*;
(
	// Routing code.
	input  wire logic [2:0] irq_pin_route,
	// Sources, bit 0 is the detach source.
	input  wire logic [4:0] sources,
	// Pins.
	output logic            pin_one,
	output logic            pin_two
);

	// Returns the mask of sources sent to the second pin.
	function automatic logic [4:0] to_second(input logic [2:0] code);
		case (code)
			3'h1:    to_second = 5'h1F;
			3'h2:    to_second = 5'h08;
			3'h3:    to_second = 5'h04;
			3'h4:    to_second = 5'h02;
			3'h5:    to_second = 5'h01;
			3'h6:    to_second = 5'h10;
			default: to_second = 5'h00;
		endcase
	endfunction

	logic       none;
	logic [4:0] second;

	assign none    = (irq_pin_route == ROUTE_NONE); // R08
	assign second  = to_second(irq_pin_route); // R08
	assign pin_one = !none && |(sources & ~second);
	assign pin_two = !none && |(sources & second);

endmodule

//--- locr_top.sv
// Lead-off current step and pad configuration register bank with an
// Avalon-MM slave, interrupt status and mask, and pin interrupt routing.
// Assumes a byte-addressed Avalon-MM master on ref_clk.
//
// Behaviour
// R01: Frame-miss check bit flags missed direct frames on slow reads; resets to 0.
// R02: The frame-miss check ignores overwrites inside the sample FIFO.
// R03: Feature bit 1 selects strong pad drive; resets to 0.
// R04: Feature bit 0 enables pad slew-limited mode; resets to 1.
// R05: Step bit 7 enables lead-off interrupt onto a general-purpose pin; resets 0.
// R06: Step bit 6 picks coarse field when 0, fine step code when 1.
// R07: Step bits 5 to 0 hold fine code, reset zero, one step each.
// R08: Five sources routed to pin one or two by 3-bit field; reset routes none.
// R09: Fine code drives the DAC as code times step while fine is selected.
`timescale 1ns/1ns
module locr_top
	import locr_pkg::*;
(
	// Clock and reset.
	input  wire logic                ref_clk,
	input  wire logic                reset_n,
	// Avalon-MM slave.
	input  wire logic [7:0]          address,
	input  wire logic                read,
	input  wire logic                write,
	input  wire logic [31:0]         writedata,
	input  wire logic [3:0]          byteenable,
	output logic      [31:0]         readdata,
	output logic                     waitrequest,
	// Frame events from the conversion path.
	input  wire logic                frame_new,
	input  wire logic                frame_to_fifo,
	input  wire logic                frame_taken,
	// Lead-off comparator, asynchronous.
	input  wire logic                electrode_detached,
	// Other interrupt sources, same clock.
	input  wire logic [3:0]          other_irq_sources,
	// Coarse current setting from elsewhere.
	input  wire logic [1:0]          coarse_current_code,
	// Pad, oscillator, frame-miss check and invalid-command interrupt controls.
	output logic                     pad_strong_drive_on,
	output logic                     pad_slew_limit_on,
	output logic                     frame_miss_check_on,
	output logic                     osc_check_on,
	output logic                     invalid_cmd_irq_on,
	// Current DAC setting.
	output locr_dac_t                dac_setting,
	// Interrupt outputs.
	output logic                     gpio_irq_one,
	output logic                     gpio_irq_two,
	output logic                     irq
);

	locr_config_five_t  config_five;
	locr_current_step_t current_step;
	logic [7:0]         threshold_step;
	logic [IRQ_BITS-1:0] irq_status;
	logic [IRQ_BITS-1:0] irq_mask;
	logic [IRQ_BITS-1:0] irq_events;
	logic [IRQ_BITS-1:0] irq_clear;
	logic [5:0]         index;
	logic               wr_now;
	logic [7:0]         wr_byte;
	logic [31:0]        next_readdata;
	logic [2:0]         detach_sync;
	logic               detach_level;
	logic               detach_rise;
	logic               frame_miss;
	logic [4:0]         sources;
	logic               route_one;
	logic               route_two;

	assign index   = address[7:2];
	assign wr_byte = writedata[7:0];
	// Writes land at the edge where the master sees waitrequest low.
	assign wr_now  = write && !waitrequest && byteenable[0];

	// Bus handshake: one wait cycle, then a single ready cycle.
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			waitrequest <= 1'b1;
		else
			waitrequest <= !((read || write) && waitrequest);
	end

	// Feature configuration register.
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			config_five <= RST_FEATURE_CONFIG_FIVE; // R01 R03 R04 R08
		else if (wr_now && index == IDX_FEATURE_CONFIG_FIVE)
			config_five <= wr_byte;
	end

	// Lead-off current step register.
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			current_step <= RST_LEADOFF_CURRENT_STEP; // R05 R06 R07
		else if (wr_now && index == IDX_LEADOFF_CURRENT_STEP)
			current_step <= wr_byte;
	end

	// Threshold step register; held and read back only, it drives no output.
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			threshold_step <= RST_LEADOFF_THRESHOLD_STEP;
		else if (wr_now && index == IDX_LEADOFF_THRESHOLD_STEP)
			threshold_step <= wr_byte;
	end

	// Interrupt mask register.
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			irq_mask <= RST_IRQ;
		else if (wr_now && index == IDX_IRQ_MASK)
			irq_mask <= wr_byte[IRQ_BITS-1:0];
	end

	// Read mux; unmapped words and reserved bits read as zero.
	always_comb
	begin
		next_readdata = 32'h00000000;
		case (index)
			IDX_FEATURE_CONFIG_FIVE:
				next_readdata[7:0] = config_five;
			IDX_LEADOFF_CURRENT_STEP:
				next_readdata[7:0] = current_step;
			IDX_LEADOFF_THRESHOLD_STEP:
				next_readdata[7:0] = threshold_step;
			IDX_IRQ_STATUS:
				next_readdata[IRQ_BITS-1:0] = irq_status;
			IDX_IRQ_MASK:
				next_readdata[IRQ_BITS-1:0] = irq_mask;
			default:
				next_readdata = 32'h00000000;
		endcase
	end

	// Read data is loaded as waitrequest falls, so it stands at that edge.
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			readdata <= 32'h00000000;
		else if (read && waitrequest)
			readdata <= next_readdata;
	end

	// Comparator synchroniser; the first stage feeds only the second.
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			detach_sync <= 3'h0;
		else
			detach_sync <= {detach_sync[1:0], electrode_detached};
	end

	// A change counts once the second and third stages agree.
	assign detach_rise = (detach_sync[1] == detach_sync[2]) &&
		detach_sync[2] && !detach_level;

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			detach_level <= 1'b0;
		else if (detach_sync[1] == detach_sync[2])
			detach_level <= detach_sync[2];
	end

	locr_frame_check u_frame_check (
		.ref_clk       (ref_clk),
		.reset_n       (reset_n),
		.check_on      (config_five.frame_miss_check_on),
		.frame_new     (frame_new),
		.frame_to_fifo (frame_to_fifo),
		.frame_taken   (frame_taken),
		.frame_miss    (frame_miss)
	);

	// Sticky status, write one to clear; a new event beats the clear.
	assign irq_events[IRQ_BIT_FRAME_MISS] = frame_miss;
	assign irq_events[IRQ_BIT_DETACH]     = detach_rise;
	assign irq_clear = (wr_now && index == IDX_IRQ_STATUS) ?
		wr_byte[IRQ_BITS-1:0] : RST_IRQ;

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			irq_status <= RST_IRQ;
		else
			irq_status <= (irq_status & ~irq_clear) | irq_events;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end

	// The detach source reaches a pin only while its enable is set.
	assign sources = {other_irq_sources,
		current_step.electrode_detach_irq_on &&
		irq_status[IRQ_BIT_DETACH]}; // R05

	locr_irq_route u_irq_route (
		.irq_pin_route (config_five.irq_pin_route),
		.sources       (sources),
		.pin_one       (route_one),
		.pin_two       (route_two)
	);

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			gpio_irq_one <= 1'b0;
			gpio_irq_two <= 1'b0;
		end
		else
		begin
			gpio_irq_one <= route_one; // R08
			gpio_irq_two <= route_two; // R08
		end
	end

	// DAC setting; the product is computed only while fine is chosen.
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			dac_setting <= '0;
		else
		begin
			dac_setting.fine_selected <= current_step.current_source_select; // R06
			dac_setting.coarse_current_code <= coarse_current_code; // R06
			if (current_step.current_source_select)
				dac_setting.fine_magnitude <=
					MAG_BITS'(current_step.fine_current_code) *
					MAG_BITS'(FINE_STEP_TENTHS_NA); // R07 R09
			else
				dac_setting.fine_magnitude <= '0;
		end
	end

	// Pad controls follow the register one cycle later, as flops.
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			pad_strong_drive_on <= 1'b0;
			pad_slew_limit_on   <= 1'b1;
			frame_miss_check_on <= 1'b0;
			osc_check_on        <= 1'b0;
			invalid_cmd_irq_on  <= 1'b0;
		end
		else
		begin
			pad_strong_drive_on <= config_five.pad_strong_drive_on; // R03
			pad_slew_limit_on   <= config_five.pad_slew_limit_on; // R04
			frame_miss_check_on <= config_five.frame_miss_check_on; // R01
			osc_check_on        <= config_five.osc_check_on;
			invalid_cmd_irq_on  <= config_five.invalid_cmd_irq_on;
		end
	end

endmodule

//--- locr_asserts.sv
// Port checks for locr_top, bound in after the module.
// Assumes one clock domain and one wait cycle per bus access.
`timescale 1ns/1ns
module locr_asserts
	import locr_pkg::*;
(
	// Clock and reset.
	input wire logic        ref_clk,
	input wire logic        reset_n,
	// Bus.
	input wire logic [7:0]  address,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic        waitrequest,
	// Watched outputs, and the coarse code input.
	input wire logic [1:0]  coarse_current_code,
	input wire locr_dac_t   dac_setting,
	input wire logic        frame_miss_check_on,
	input wire logic        pad_strong_drive_on,
	input wire logic        pad_slew_limit_on,
	input wire logic        gpio_irq_one,
	input wire logic        gpio_irq_two,
	input wire logic        irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic touched;

	// Routing stays at none until software writes the feature register.
	always_ff @(posedge ref_clk)
		if (!reset_n)
			touched <= 1'b0;
		else if (write && !waitrequest && byteenable[0]
			&& address[7:2] == IDX_FEATURE_CONFIG_FIVE)
			touched <= 1'b1;

	sequence wr_at(logic [5:0] i);
		write && !waitrequest && byteenable[0] && address[7:2] == i;
	endsequence

	rst_cfg_a: assert property ($rose(reset_n) |-> pad_slew_limit_on
		&& !pad_strong_drive_on && !frame_miss_check_on)
		else $error("pad bits wrong after reset");
	rst_dac_a: assert property ($rose(reset_n) |-> dac_setting == '0
		&& !gpio_irq_one && !gpio_irq_two && !irq)
		else $error("dac or pins wrong after reset");
	mag_step_a: assert property (dac_setting.fine_magnitude % 22 == 0
		&& (dac_setting.fine_selected || dac_setting.fine_magnitude == 0))
		else $error("fine magnitude not a step multiple");
	coarse_pass_a: assert property ($past(reset_n) |->
		dac_setting.coarse_current_code == $past(coarse_current_code))
		else $error("coarse code not passed on");
	cfg_upd_a: assert property (wr_at(IDX_FEATURE_CONFIG_FIVE) |-> ##2
		{frame_miss_check_on, pad_strong_drive_on, pad_slew_limit_on}
		== $past(writedata[2:0], 2)) else $error("pad bits not updated");
	step_upd_a: assert property (wr_at(IDX_LEADOFF_CURRENT_STEP) |-> ##2
		dac_setting.fine_selected == $past(writedata[6], 2)
		&& dac_setting.fine_magnitude == ($past(writedata[6], 2)
		? 22 * $past(writedata[5:0], 2) : 0)) else $error("dac not updated");
	mask_off_a: assert property (wr_at(IDX_IRQ_MASK)
		##0 writedata[1:0] == 2'h0 |-> ##2 !irq)
		else $error("irq high with all masked");
	route_none_a: assert property (!touched |->
		!gpio_irq_one && !gpio_irq_two) else $error("pin irq before routing");
endmodule

bind locr_top locr_asserts locr_asserts_i (.ref_clk, .reset_n, .address,
	.write, .writedata, .byteenable, .waitrequest, .coarse_current_code,
	.dac_setting, .frame_miss_check_on, .pad_strong_drive_on,
	.pad_slew_limit_on, .gpio_irq_one, .gpio_irq_two, .irq);

//--- locr_host.sv
// Host controller model: an Avalon-MM master with one access task.
// Assumes the slave answers by lowering waitrequest on ref_clk.
`timescale 1ns/1ns
module locr_host
(
	// Bus.
	input  wire logic        ref_clk,
	input  wire logic        waitrequest,
	input  wire logic [31:0] readdata,
	output logic      [7:0]  address,
	output logic             read,
	output logic             write,
	output logic      [31:0] writedata,
	output logic      [3:0]  byteenable
);
	initial
	begin
		{address, read, write, writedata, byteenable} = '0;
	end

	// The request is held until waitrequest is seen low at an edge.
	task automatic acc(input logic w, input logic [5:0] i,
		input logic [7:0] d, input logic be, output logic [31:0] q);
		@(posedge ref_clk);
		address <= {i, 2'h0};
		writedata <= {24'h0, d};
		byteenable <= {3'h0, be};
		write <= w;
		read <= !w;
		do
			@(posedge ref_clk);
		while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
endmodule

//--- locr_bench.sv
// Self-checking bench for locr_top against a register model.
// Assumes the host model for bus traffic and a 10 MHz ref_clk.
`timescale 1ns/1ns
module locr_bench
	import locr_pkg::*;
;
	logic        ref_clk, reset_n, read, write, waitrequest;
	logic        frame_new, frame_to_fifo, frame_taken;
	logic        electrode_detached, irq, gpio_irq_one, gpio_irq_two;
	logic        pad_strong_drive_on, pad_slew_limit_on;
	logic        frame_miss_check_on, osc_check_on, invalid_cmd_irq_on;
	logic [7:0]  address;
	logic [31:0] writedata, readdata;
	logic [3:0]  byteenable;
	logic [1:0]  coarse_current_code;
	logic [3:0]  other_irq_sources;
	locr_dac_t   dac_setting;
	int          errors, num_checks, k;
	int          mdl[64];
	int          idx[6] = '{14, 15, 16, 33, 7, 32};

	locr_top locr_top_i (.ref_clk, .reset_n, .address, .read, .write,
		.writedata, .byteenable, .readdata, .waitrequest, .frame_new,
		.frame_to_fifo, .frame_taken, .electrode_detached,
		.other_irq_sources, .coarse_current_code,
		.pad_strong_drive_on, .pad_slew_limit_on, .frame_miss_check_on,
		.osc_check_on, .invalid_cmd_irq_on, .dac_setting, .gpio_irq_one,
		.gpio_irq_two, .irq);
	locr_host locr_host_i (.ref_clk, .waitrequest, .readdata, .address,
		.read, .write, .writedata, .byteenable);

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr(input int i, input int d, input logic be = 1'b1);
		logic [31:0] q;
		locr_host_i.acc(1'b1, i[5:0], d[7:0], be, q);
		if (be && i == 32)
			mdl[32] &= ~d;
		else if (be && i == 33)
			mdl[33] = d & 3;
		else if (be && i inside {14, 15, 16})
			mdl[i] = d & 8'hFF;
	endtask

	task automatic rd_cmp(input int i);
		logic [31:0] q;
		locr_host_i.acc(1'b0, i[5:0], 8'h00, 1'b0, q);
		cmp(q, mdl[i]);
	endtask

	function automatic logic [21:0] exp_out();
		int f, s, r, d, m;
		logic [4:0] src;
		f = mdl[14];
		s = mdl[15];
		r = f[6:4];
		d = s[7] & mdl[32][1];
		src = {other_irq_sources, d[0]};
		m = (r == 1) ? 31 : (r == 6) ? 16 :
			(r inside {[2:5]}) ? 1 << (5 - r) : 0;
		return {s[6], coarse_current_code, 11'(s[6] ? s[5:0] * 22 : 0),
			f[7], f[3], f[2:0], r != 7 && (src & ~m[4:0]) != 0,
			r != 7 && (src & m[4:0]) != 0, (mdl[32] & mdl[33]) != 0};
	endfunction

	// Long enough for the detach synchroniser, status and pin stages.
	task automatic out_cmp();
		repeat (8) @(posedge ref_clk);
		cmp({dac_setting, osc_check_on, invalid_cmd_irq_on,
			frame_miss_check_on, pad_strong_drive_on, pad_slew_limit_on,
			gpio_irq_one, gpio_irq_two, irq}, exp_out());
	endtask

	task automatic pulse(input logic n, input logic f, input logic t);
		@(posedge ref_clk);
		frame_new <= n;
		frame_to_fifo <= f;
		frame_taken <= t;
		@(posedge ref_clk);
		frame_new <= 1'b0;
		frame_taken <= 1'b0;
	endtask

	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	initial
	begin
		#(4000 * 100);
		errors++;
		tally_and_finish();
	end

	initial
	begin
		{reset_n, frame_new, frame_to_fifo, frame_taken} = '0;
		electrode_detached = 1'b0;
		coarse_current_code = 2'h0;
		other_irq_sources = 4'h0;
		mdl = '{default: 0};
		mdl[14] = 8'h71;
		void'($urandom(32'h9E03BC0F));
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		foreach (idx[j])
			rd_cmp(idx[j]);
		out_cmp();
		repeat (24)
		begin
			k = idx[$urandom_range(4)];
			@(posedge ref_clk);
			coarse_current_code <= 2'($urandom);
			other_irq_sources <= 4'($urandom);
			wr(k, $urandom, 1'($urandom));
			out_cmp();
			rd_cmp(k);
		end
		wr(33, 3);
		wr(14, 8'h75);
		pulse(1'b1, 1'b0, 1'b0);
		pulse(1'b1, 1'b1, 1'b0);
		out_cmp();
		pulse(1'b0, 1'b0, 1'b1);
		pulse(1'b1, 1'b0, 1'b0);
		pulse(1'b1, 1'b0, 1'b0);
		mdl[32] |= 1;
		out_cmp();
		wr(32, 1);
		rd_cmp(32);
		wr(14, 8'h71);
		pulse(1'b1, 1'b0, 1'b0);
		pulse(1'b1, 1'b0, 1'b0);
		rd_cmp(32);
		wr(33, 2);
		wr(14, 8'h75);
		pulse(1'b0, 1'b0, 1'b1);
		pulse(1'b1, 1'b0, 1'b0);
		pulse(1'b1, 1'b0, 1'b0);
		mdl[32] |= 1;
		out_cmp();
		wr(15, 8'hC5);
		electrode_detached <= 1'b1;
		mdl[32] |= 2;
		for (k = 0; k < 8; k++)
		begin
			@(posedge ref_clk);
			other_irq_sources <= 4'($urandom);
			wr(14, k * 16 + 1);
			out_cmp();
		end
		wr(14, 8'h01);
		wr(15, 8'h45);
		out_cmp();
		wr(33, 0);
		wr(32, 3);
		out_cmp();
		rd_cmp(32);
		tally_and_finish();
	end
endmodule
